// >>> hw/pwt_top.v
/*
 * pwt_top.v: 16-bit pwm timer with prescalers, run control, output
 * levels, forced output stop 2 and an axi4-lite register slave.
 * assumes: all inputs synchronous to sys_clk_i; one write and one read
 * at most in flight; the oscillator clock is sys_clk_i itself.
 */
// Our own choices: the register offsets and register access over AXI4-Lite.
`include "pwt_map.vh"
`timescale 1ns/1ns
`default_nettype none

module pwt_top #(
    parameter CNT_W = 16
) (
    // clock and reset
    input  wire        sys_clk_i,
    input  wire        rstn_i,
    // axi4-lite write
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // axi4-lite read
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // trigger sources
    input  wire        external_irq_input_a_i,
    input  wire        external_irq_input_b_i,
    input  wire        cmp0_i,
    input  wire        cmp1_i,
    // outputs
    output reg  [1:0]  pwm_output_pin_o,
    output wire        irq_o
);

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    reg  [7:0]       rst_ff;
    reg  [7:0]       cken_ff;
    reg  [7:0]       tps_ff;
    reg              if_ff;
    reg              mk_ff;
    reg  [7:0]       ctl_ff;
    reg  [7:0]       ioc_ff;
    reg  [15:0]      pactl0_ff;
    reg  [7:0]       pactl2_ff;
    reg  [CNT_W-1:0] period_ff;
    reg  [CNT_W-1:0] duty0_ff;
    reg  [CNT_W-1:0] duty1_ff;
    reg  [CNT_W-1:0] cnt_ff;
    reg  [4:0]       pre_ff;
    reg              stop_ff;
    reg              rev_seen_ff;
    reg              trig_d_ff;
    reg              aw_ok_ff;
    reg              w_ok_ff;
    reg  [7:0]       aw_ff;
    reg  [31:0]      wd_ff;
    reg  [3:0]       ws_ff;

    wire timer_rst  = rst_ff[`PWT_BIT_RES];
    wire timer_clk  = cken_ff[`PWT_BIT_EN] & ~timer_rst;
    wire run        = ctl_ff[`PWT_BIT_RUN];

    // ------------------------------------------------------------
    // prescaler: enable pulse every 2^code cycles for codes 0 to 5, every 32 for codes 6 and 7
    // ------------------------------------------------------------
    function [4:0] div_mask;
        input [2:0] code;
        begin
            case (code)
                3'h0: div_mask = 5'h00;
                3'h1: div_mask = 5'h01;
                3'h2: div_mask = 5'h03;
                3'h3: div_mask = 5'h07;
                3'h4: div_mask = 5'h0f;
                3'h5: div_mask = 5'h1f;
                default: div_mask = 5'h1f; // prohibited codes behave as /32
            endcase
        end
    endfunction

    wire [2:0] sel_code = ctl_ff[`PWT_BIT_CKS] ? tps_ff[6:4] : tps_ff[2:0];
    wire [4:0] msk      = div_mask(sel_code);
    wire       tick     = timer_clk && ((pre_ff & msk) == msk);

    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pre_ff <= 5'h00;
        end else if (!timer_clk) begin
            pre_ff <= 5'h00;
        end else begin
            pre_ff <= pre_ff + 5'h01;
        end
    end

    // ------------------------------------------------------------
    // counter: period end is the release point for forced stop
    // ------------------------------------------------------------
    wire period_end = tick && run && (cnt_ff == period_ff);

    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_ff <= `PWT_CNT_STOP;
        end else if (timer_rst || !run) begin
            cnt_ff <= `PWT_CNT_STOP;
        end else if (tick) begin
            if (cnt_ff >= period_ff) begin
                cnt_ff <= {CNT_W{1'b0}};
            end else begin
                cnt_ff <= cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // ------------------------------------------------------------
    // forced output stop 2
    // ------------------------------------------------------------
    wire trig = (pactl0_ff[`PWT_BIT_SEL_EXTB] & external_irq_input_b_i)
              | (pactl0_ff[`PWT_BIT_SEL_EXTA] & external_irq_input_a_i)
              | (pactl0_ff[`PWT_BIT_SEL_CMP1] & cmp1_i)
              | (pactl0_ff[`PWT_BIT_SEL_CMP0] & cmp0_i);
    wire trig_rise = trig & ~trig_d_ff;
    wire trig_fall = ~trig & trig_d_ff;
    wire rev_mode  = pactl0_ff[`PWT_BIT_FCM];

    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            stop_ff     <= 1'b0;
            rev_seen_ff <= 1'b0;
            trig_d_ff   <= 1'b0;
        end else if (timer_rst) begin
            stop_ff     <= 1'b0;
            rev_seen_ff <= 1'b0;
            trig_d_ff   <= 1'b0;
        end else begin
            trig_d_ff <= trig;
            // a new trigger edge wins over a release in the same cycle
            if (trig_rise) begin
                stop_ff     <= 1'b1;
                rev_seen_ff <= 1'b0;
            end else if (stop_ff && !rev_mode && period_end) begin
                stop_ff <= 1'b0;
            end else if (stop_ff && rev_mode) begin
                if (trig_fall) begin
                    rev_seen_ff <= 1'b1;
                end
                if ((rev_seen_ff || trig_fall) && period_end) begin
                    stop_ff     <= 1'b0;
                    rev_seen_ff <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // output stage
    // ------------------------------------------------------------
    wire        active_mode = (ctl_ff[1:0] == `PWT_MODE_ALONE) ||
                              (ctl_ff[1:0] == `PWT_MODE_ILV);
    wire [1:0]  raw;
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_out
            wire [CNT_W-1:0] duty = (g == 0) ? duty0_ff : duty1_ff;
            // interleave mode shifts the second output by half a period, wrapped
            // back into the period so the shifted phase still crosses the duty
            wire [CNT_W:0]   sum  = {1'b0, cnt_ff} + {2'b00, period_ff[CNT_W-1:1]};
            wire [CNT_W:0]   wrap = sum - {1'b0, period_ff} - {{CNT_W{1'b0}}, 1'b1};
            wire [CNT_W-1:0] sft  = (sum > {1'b0, period_ff}) ? wrap[CNT_W-1:0] : sum[CNT_W-1:0];
            wire [CNT_W-1:0] ph   = (g == 1 && ctl_ff[1:0] == `PWT_MODE_ILV) ? sft : cnt_ff;
            assign raw[g] = run && active_mode && (ph < duty);
        end
    endgenerate

    integer k;
    reg [1:0] nxt_out;
    always @* begin
        for (k = 0; k < 2; k = k + 1) begin
            if (stop_ff && pactl2_ff[k]) begin
                nxt_out[k] = pactl0_ff[0];
            end else if (!run) begin
                nxt_out[k] = ioc_ff[k];
            end else begin
                nxt_out[k] = raw[k] ^ ioc_ff[k+2];
            end
        end
    end

    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pwm_output_pin_o <= 2'h0;
        end else begin
            pwm_output_pin_o <= nxt_out;
        end
    end

    // ------------------------------------------------------------
    // axi4-lite slave
    // ------------------------------------------------------------
    assign s_axi_awready = !aw_ok_ff && !s_axi_bvalid;
    assign s_axi_wready  = !w_ok_ff && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    wire do_wr = aw_ok_ff && w_ok_ff;
    wire do_rd = s_axi_arvalid && s_axi_arready;

    function [31:0] wmerge;
        input [31:0] old;
        input [31:0] d;
        input [3:0]  s;
        integer      i;
        begin
            for (i = 0; i < 4; i = i + 1) begin
                wmerge[i*8 +: 8] = s[i] ? d[i*8 +: 8] : old[i*8 +: 8];
            end
        end
    endfunction

    // low two byte lanes only; no writable register here is wider than 16 bits
    function [15:0] lane16;
        input [15:0] old;
        input [31:0] d;
        input [3:0]  s;
        begin
            lane16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
        end
    endfunction

    wire [31:0] ws = wmerge(32'h0000_0000, wd_ff, ws_ff);
    wire        wr_if  = do_wr && (aw_ff == `PWT_OFS_IF) && ws_ff[0];
    wire        rd_if  = do_rd && (s_axi_araddr == `PWT_OFS_IF);
    wire        irq_ev = period_end || trig_rise;

    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            aw_ok_ff     <= 1'b0;
            w_ok_ff      <= 1'b0;
            aw_ff        <= 8'h00;
            wd_ff        <= 32'h0000_0000;
            ws_ff        <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ok_ff <= 1'b1;
                aw_ff    <= {s_axi_awaddr[7:2], 2'h0};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ok_ff <= 1'b1;
                wd_ff   <= s_axi_wdata;
                ws_ff   <= s_axi_wstrb;
            end
            if (do_wr) begin
                aw_ok_ff     <= 1'b0;
                w_ok_ff      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_ff > `PWT_OFS_STAT) ? 2'h2 : 2'h0;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // register writes; unwritten lanes keep their value
    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_ff    <= `PWT_RST_RES;
            cken_ff   <= 8'h00;
            tps_ff    <= 8'h00;
            mk_ff     <= 1'b1;
            ctl_ff    <= 8'h00;
            ioc_ff    <= 8'h00;
            pactl0_ff <= `PWT_RST_PACTL0;
            pactl2_ff <= `PWT_RST_PACTL2;
            period_ff <= `PWT_RST_PERIOD;
            duty0_ff  <= {CNT_W{1'b0}};
            duty1_ff  <= {CNT_W{1'b0}};
        end else if (do_wr) begin
            case (aw_ff)
                `PWT_OFS_RST:    rst_ff    <= (ws_ff[0] ? wd_ff[7:0] : rst_ff) & 8'h01;
                `PWT_OFS_CKEN:   cken_ff   <= (ws_ff[0] ? wd_ff[7:0] : cken_ff) & 8'h01;
                `PWT_OFS_TPS:    tps_ff    <= (ws_ff[0] ? wd_ff[7:0] : tps_ff) & 8'h77;
                `PWT_OFS_MK:     mk_ff     <= ws_ff[0] ? wd_ff[`PWT_BIT_IRQ] : mk_ff;
                `PWT_OFS_CTL:    ctl_ff    <= (ws_ff[0] ? wd_ff[7:0] : ctl_ff) & 8'h93;
                `PWT_OFS_IOC:    ioc_ff    <= (ws_ff[0] ? wd_ff[7:0] : ioc_ff) & 8'h0f;
                `PWT_OFS_PACTL0: pactl0_ff <= lane16(pactl0_ff, wd_ff, ws_ff) & 16'hf13f;
                `PWT_OFS_PACTL2: pactl2_ff <= (ws_ff[0] ? wd_ff[7:0] : pactl2_ff) & 8'h03;
                `PWT_OFS_PERIOD: period_ff <= lane16(period_ff, wd_ff, ws_ff);
                `PWT_OFS_DUTY0:  duty0_ff  <= lane16(duty0_ff, wd_ff, ws_ff);
                `PWT_OFS_DUTY1:  duty1_ff  <= lane16(duty1_ff, wd_ff, ws_ff);
                default: ;
            endcase
        end
    end

    // irq flag: event set wins over software clear
    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            if_ff <= 1'b0;
        end else if (irq_ev) begin
            if_ff <= 1'b1;
        end else if (rd_if || (wr_if && !ws[`PWT_BIT_IRQ])) begin
            if_ff <= 1'b0;
        end
    end

    assign irq_o = if_ff && !mk_ff;

    reg [31:0] rd_mux;
    always @* begin
        rd_mux = 32'h0000_0000;
        case (s_axi_araddr & 8'hfc)
            `PWT_OFS_RST:    rd_mux = {24'h0, rst_ff};
            `PWT_OFS_CKEN:   rd_mux = {24'h0, cken_ff};
            `PWT_OFS_TPS:    rd_mux = {24'h0, tps_ff};
            `PWT_OFS_IF:     rd_mux = {26'h0, if_ff, 5'h00};
            `PWT_OFS_MK:     rd_mux = {26'h0, mk_ff, 5'h00};
            `PWT_OFS_CTL:    rd_mux = {24'h0, ctl_ff};
            `PWT_OFS_IOC:    rd_mux = {24'h0, ioc_ff};
            `PWT_OFS_PACTL0: rd_mux = {16'h0, pactl0_ff};
            `PWT_OFS_PACTL2: rd_mux = {24'h0, pactl2_ff};
            `PWT_OFS_PERIOD: rd_mux = {16'h0, period_ff};
            `PWT_OFS_DUTY0:  rd_mux = {16'h0, duty0_ff};
            `PWT_OFS_DUTY1:  rd_mux = {16'h0, duty1_ff};
            `PWT_OFS_STAT:   rd_mux = {13'h0, rev_seen_ff, stop_ff, 1'b0, cnt_ff};
            default:         rd_mux = 32'h0000_0000;
        endcase
    end

    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= 2'h0;
        end else if (do_rd) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= ((s_axi_araddr & 8'hfc) > `PWT_OFS_STAT) ? 2'h2 : 2'h0;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule // pwt_top

`default_nettype wire

// >>> hw/pwt_map.vh
/*
 * pwt_map.vh: register offsets, field positions, reset values and
 * timing constants of the pwm timer block.
 * assumes: included by bare name from the design file; axi4-lite 32-bit.
 */
// Function
// - timer held in reset while reset bit set
// - clock enable bit gates the timer clock
// - first prescaler divides oscillator by 1 to 32
// - clock select picks first or second prescaler
// - hardware sets interrupt flag, software clears it
// - mask bit zero enables interrupt servicing
// - run bit zero stops counter at ffff
// - mode field: 00 standalone, 11 interleave
// - active level bit: 0 high, 1 low
// - default level bit: 0 low, 1 high
// - external irq inputs selectable as stop triggers
// - comparators selectable as stop triggers
// - mode 0: stop cleared at next period
// - mode 1: clear after opposite edge, next period
// - per-output trigger enable for forced stop
// - stop output state low or high by code
`ifndef PWT_MAP_VH
`define PWT_MAP_VH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define PWT_OFS_RST      8'h00
`define PWT_OFS_CKEN     8'h04
`define PWT_OFS_TPS      8'h08
`define PWT_OFS_IF       8'h0c
`define PWT_OFS_MK       8'h10
`define PWT_OFS_CTL      8'h14
`define PWT_OFS_IOC      8'h18
`define PWT_OFS_PACTL0   8'h1c
`define PWT_OFS_PACTL2   8'h20
`define PWT_OFS_PERIOD   8'h24
`define PWT_OFS_DUTY0    8'h28
`define PWT_OFS_DUTY1    8'h2c
`define PWT_OFS_STAT     8'h30

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define PWT_BIT_RES      0
`define PWT_BIT_EN       0
`define PWT_BIT_IRQ      5
`define PWT_BIT_RUN      7
`define PWT_BIT_CKS      4
`define PWT_BIT_FCM      8
`define PWT_BIT_SEL_CMP0 12
`define PWT_BIT_SEL_CMP1 13
`define PWT_BIT_SEL_EXTA 14
`define PWT_BIT_SEL_EXTB 15

// ------------------------------------------------------------
// reset values and codes
// ------------------------------------------------------------
`define PWT_RST_RES      8'h01
`define PWT_RST_MK       8'h20
`define PWT_RST_PACTL0   16'h0012
`define PWT_RST_PACTL2   8'h01
`define PWT_RST_PERIOD   16'hffff
`define PWT_CNT_STOP     16'hffff
`define PWT_MAX_DIV_CODE 3'h5
`define PWT_MODE_ALONE   2'h0
`define PWT_MODE_ILV     2'h3

`endif

// >>> tb/pwt_chk.sv
/* pwt_chk.sv: assertions on the register bus ports of the pwm timer.
   assumes: bound to pwt_top; one clock, reset asynchronous and low. */
`timescale 1ns/1ns
`default_nettype none
module pwt_chk #(
    parameter CNT_W = 16
) (
    // clock and reset
    input wire logic        sys_clk_i,
    input wire logic        rstn_i,
    // axi4-lite write
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    // axi4-lite read
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready
);
    // ----------------------------------------
    // bus properties
    // ----------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);
    sequence seq_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence seq_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_write_latency: assert property (seq_wr_taken |-> ##2 s_axi_bvalid)
        else $error("write response not two cycles after address and data");
    a_read_latency: assert property (seq_rd_taken |=> s_axi_rvalid)
        else $error("read data not one cycle after address");
    a_unmapped_rd: assert property (seq_rd_taken ##0 ((s_axi_araddr & 8'hfc) > 8'h30)
        |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read answered");
    a_mapped_rd: assert property (seq_rd_taken ##0 ((s_axi_araddr & 8'hfc) <= 8'h30)
        |=> s_axi_rresp == 2'h0) else $error("mapped read refused");
    a_unmapped_wr: assert property (seq_wr_taken ##0 ((s_axi_awaddr & 8'hfc) > 8'h30)
        |-> ##2 s_axi_bresp == 2'h2) else $error("unmapped write answered okay");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read data dropped before taken");
    a_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while data pending");
    a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
endmodule // pwt_chk
bind pwt_top pwt_chk #(.CNT_W(CNT_W)) pwt_chk_i (.sys_clk_i, .rstn_i, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// >>> tb/pwt_led_stage.sv
/* pwt_led_stage.sv: power stage with its over-current comparator.
   assumes: fault_i is the bench asking the stage to draw excess current. */
`timescale 1ns/1ns
`default_nettype none
module pwt_led_stage (
    // clock and reset
    input  wire logic sys_clk_i,
    input  wire logic rstn_i,
    // stage side
    input  wire logic fault_i,
    output var  logic cmp0_o
);
    // ----------------------------------------
    // comparator
    // ----------------------------------------
    // sense path lags the current by one cycle, so the timer never sees it early
    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cmp0_o <= 1'b0;
        end else begin
            cmp0_o <= fault_i;
        end
    end
endmodule // pwt_led_stage
`default_nettype wire

// >>> tb/pwt_bench.sv
/* pwt_bench.sv: self-checking bench of the pwm timer.
   assumes: pwt_top, pwt_chk and pwt_led_stage are compiled with it. */
`timescale 1ns/1ns
`include "pwt_map.vh"
`default_nettype none
module pwm_timer_forced_stop_setup_bench;
    // ----------------------------------------
    // signals and rows
    // ----------------------------------------
    logic        clk = 1'b0, rstn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
    logic        bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rd;
    logic [3:0]  trig = 4'h0; // ext b, ext a, cmp1, cmp0 fault
    logic [1:0]  rs;
    logic [15:0] dlt;
    wire         awready, wready, bvalid, arready, rvalid, cmp0, irq;
    wire  [1:0]  bresp, rresp, pins;
    wire  [31:0] rdata;
    int          error_cnt = 0, num_checks = 0, i, n;
    logic [7:0]  p_tps [9] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h30, 8'h13};
    logic        p_cks [9] = '{0, 0, 0, 0, 0, 0, 0, 1, 1};
    int          p_div [9] = '{1, 2, 4, 8, 16, 32, 32, 8, 2};
    logic [7:0]  r_adr [10] = '{0, 4, 8, 8'hc, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24};
    logic [31:0] r_val [10] = '{1, 0, 0, 0, 8'h20, 0, 0, 8'h12, 1, 16'hffff};
    always #2 clk = ~clk;
    pwt_top pwt_top_i (.sys_clk_i(clk), .rstn_i(rstn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .external_irq_input_a_i(trig[2]),
        .external_irq_input_b_i(trig[3]), .cmp0_i(cmp0), .cmp1_i(trig[1]),
        .pwm_output_pin_o(pins), .irq_o(irq));
    pwt_led_stage pwt_led_stage_i (.sys_clk_i(clk), .rstn_i(rstn), .fault_i(trig[0]),
        .cmp0_o(cmp0));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic report_and_stop;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (k = 0; k < 50 && !(bvalid === 1'b1); k++) begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end
        if (k == 50) begin
            chk("write timeout", 0, 1);
            report_and_stop();
        end
        bready <= 1'b0;
        rs = bresp;
    endtask
    // a late rready lets the bench see the read answer held
    task automatic rd_(input logic [7:0] a, input int hold);
        int k;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= (hold == 0);
        for (k = 0; k < 50 && !(rvalid === 1'b1 && rready); k++) begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
            if (k >= hold) rready <= 1'b1;
        end
        if (k == 50) begin
            chk("read timeout", 0, 1);
            report_and_stop();
        end
        rready <= 1'b0;
        rd = rdata;
        rs = rresp;
    endtask
    task automatic cnt_delta(input int cyc);
        logic [15:0] c0;
        rd_(`PWT_OFS_STAT, 0);
        c0 = rd[15:0];
        repeat (cyc) @(posedge clk);
        rd_(`PWT_OFS_STAT, 0);
        dlt = rd[15:0] - c0;
    endtask
    task automatic wait_pin(input logic v, input int lim);
        int k;
        for (k = 0; k < lim && pins[0] !== v; k++) @(posedge clk);
        chk("pin0", pins[0], v);
    endtask
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        chk("pins after reset", pins, 0);
        for (i = 0; i < 10; i++) begin
            rd_(r_adr[i], 0);
            chk("reset value", rd, r_val[i]);
        end
        wr(`PWT_OFS_CKEN, 32'h1);
        wr(`PWT_OFS_RST, 32'h0);
        for (i = 0; i < 9; i++) begin
            wr(`PWT_OFS_TPS, p_tps[i]);
            wr(`PWT_OFS_CTL, {24'h0, 3'h4, p_cks[i], 4'h0});
            cnt_delta(256);
            n = dlt * p_div[i];
            chk("count rate", n > 200 && n < 320, 1);
        end
        wr(`PWT_OFS_CKEN, 32'h0);
        cnt_delta(64);
        chk("gated count", dlt, 0);
        wr(`PWT_OFS_CKEN, 32'h1);
        cnt_delta(64);
        chk("ungated count", dlt != 0, 1);
        wr(`PWT_OFS_RST, 32'h1);
        cnt_delta(64);
        chk("held count", dlt, 0);
        wr(`PWT_OFS_RST, 32'h0);
        wr(`PWT_OFS_TPS, 32'h0);
        wr(`PWT_OFS_CTL, 32'h0);
        rd_(`PWT_OFS_STAT, 0);
        chk("stopped count", rd[15:0], 16'hffff);
        for (i = 0; i < 4; i++) begin
            wr(`PWT_OFS_IOC, i);
            repeat (3) @(posedge clk);
            chk("default level", pins, i);
        end
        wr(`PWT_OFS_PERIOD, 32'hf);
        wr(`PWT_OFS_CTL, 32'h80);
        for (i = 0; i < 2; i++) begin
            wr(`PWT_OFS_IOC, i ? 32'hc : 32'h0);
            repeat (3) @(posedge clk);
            chk("active level", pins, i ? 3 : 0);
        end
        wr(`PWT_OFS_DUTY0, 32'h8);
        wr(`PWT_OFS_DUTY1, 32'h8);
        for (i = 0; i < 2; i++) begin
            wr(`PWT_OFS_CTL, i ? 32'h83 : 32'h80);
            repeat (20) @(posedge clk);
            n = 0;
            repeat (32) begin
                @(posedge clk);
                n += (pins[0] !== pins[1]);
            end
            chk("interleave", n >= 24, i);
        end
        wr(`PWT_OFS_DUTY0, 32'h0);
        wr(`PWT_OFS_DUTY1, 32'h0);
        wr(`PWT_OFS_IOC, 32'h0);
        wr(`PWT_OFS_CTL, 32'h80);
        for (i = 0; i < 4; i++) begin
            wr(`PWT_OFS_PACTL0, (32'h1000 << i) | 32'h1);
            @(posedge clk);
            trig[i] <= 1'b1;
            wait_pin(1, 20);
            chk("unenabled output", pins[1], 0);
            wait_pin(0, 60);
            trig[i] <= 1'b0;
        end
        wr(`PWT_OFS_IOC, 32'h4);
        wr(`PWT_OFS_PACTL0, 32'h4102);
        @(posedge clk);
        trig[2] <= 1'b1;
        wait_pin(0, 20);
        repeat (60) @(posedge clk);
        chk("stop held", pins[0], 0);
        trig[2] <= 1'b0;
        wait_pin(1, 60);
        wr(`PWT_OFS_IOC, 32'h0);
        wr(`PWT_OFS_PACTL0, 32'h1);
        @(posedge clk);
        trig <= 4'hf;
        repeat (30) @(posedge clk);
        chk("unselected", pins[0], 0);
        trig <= 4'h0;
        wr(`PWT_OFS_CTL, 32'h0);
        rd_(`PWT_OFS_IF, 0);
        rd_(`PWT_OFS_IF, 3);
        chk("flag cleared", rd[5], 0);
        wr(`PWT_OFS_MK, 32'h0);
        wr(`PWT_OFS_PACTL0, 32'h8001);
        trig[3] <= 1'b1;
        repeat (4) @(posedge clk);
        chk("irq raised", irq, 1);
        rd_(`PWT_OFS_IF, 0);
        chk("flag read", rd[5], 1);
        @(posedge clk);
        chk("irq after read", irq, 0);
        trig[3] <= 1'b0;
        @(posedge clk);
        trig[3] <= 1'b1;
        wr(`PWT_OFS_MK, 32'h20);
        chk("irq masked", irq, 0);
        wr(`PWT_OFS_MK, 32'h0);
        chk("irq unmasked", irq, 1);
        wr(`PWT_OFS_IF, 32'h0);
        @(posedge clk);
        chk("irq cleared", irq, 0);
        rd_(8'h34, 3);
        chk("bad read resp", rs, 2);
        chk("bad read data", rd, 0);
        wr(8'h40, 32'h5);
        chk("bad write resp", rs, 2);
        report_and_stop();
    end
endmodule // pwm_timer_forced_stop_setup_bench
`default_nettype wire
